// ---- verilog/dgo_cmd.sv ----
/*
  Command decoder for glyph banks, digit and bar placement, general
  outputs and single-wire bus requests, fed by a received byte stream.
  Assumes bytes arrive with a valid/ready handshake from the link,
  a renderer consumes the draw and text pulses, and a bus engine
  performs the single-wire search and transfers.
*/
// Operation
// - Define glyph: index then eight rows
// - Rows of five pixels, top three zero
// - Loading a bank drops unsaved glyphs
// - Bank save writes slot in storage
// - Banks: boot, hbar, vbar, medium, large
// - Text byte 0-7 shows defined glyph, else saved glyph
// - Medium init loads medium digit bank
// - Medium digit: two rows, one column
// - Large digit: four rows, three columns
// - Horizontal init loads horizontal bar bank
// - Horizontal bar: column, row, direction, length
// - Narrow and wide vertical bar banks; both load BANK_VBAR here, width sent on draw_c
// - Vertical bar grows up from base
// - Output off sinks, on sources
// - Saved output state applied at start
// - Search returns fourteen-byte packet per device
// - Preamble, then more-or-last byte
// - Type, address, CRC residue byte
// - Error codes zero to three
// - Transaction: flags, counts, then data
// - Flags: reset, read CRC, add CRC
module dgo_cmd
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Received bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  // Text to renderer
  output logic text_valid_o,
  output logic [7:0] text_byte_o,
  output logic glyph_show_o,
  // Glyph row read
  input wire logic [2:0] glyph_idx_i,
  input wire logic [2:0] glyph_row_i,
  output logic [4:0] glyph_pix_o,
  output logic [2:0] active_bank_o,
  // Draw requests
  output logic draw_valid_o,
  output logic [2:0] draw_kind_o,
  output logic [7:0] draw_a_o,
  output logic [7:0] draw_b_o,
  output logic [7:0] draw_c_o,
  output logic [7:0] draw_d_o,
  output logic store_write_o,
  // General outputs
  output logic [5:0] general_output_line_o,
  // Single-wire search
  output logic sw_search_req_o,
  input wire logic sw_found_valid_i,
  input wire logic [63:0] sw_found_addr_i,
  input wire logic sw_found_last_i,
  input wire logic [1:0] sw_found_err_i,
  // Single-wire transaction
  output logic sw_txn_start_o,
  output logic [7:0] sw_txn_flags_o,
  output logic [7:0] sw_txn_send_o,
  output logic [7:0] sw_txn_recv_o,
  output logic sw_txn_valid_o,
  output logic [7:0] sw_txn_byte_o,
  // Answer bytes
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o
);

  typedef struct packed {
    dgo_pkg::dgo_state_e st;
    logic [7:0] op;
    logic [3:0] idx;
    logic [9:0][7:0] p;
    logic [7:0] rem;
    logic [3:0] pk;
    logic [63:0] addr;
    logic last;
    logic [1:0] err;
    logic [2:0] abank;
    logic vwide;
    logic [7:0][7:0][4:0] ovl;
    logic [7:0] ovl_v;
    logic [4:0][7:0][7:0][4:0] store;
    logic [5:0] boot_out;
    logic boot;
    logic rx_ready;
    logic text_v;
    logic [7:0] text_b;
    logic show;
    logic [4:0] pix;
    logic draw_v;
    logic [2:0] draw_k;
    logic [3:0][7:0] draw;
    logic st_wr;
    logic [5:0] gout;
    logic srch;
    logic t_start;
    logic [7:0] t_flags;
    logic [7:0] t_send;
    logic [7:0] t_recv;
    logic t_v;
    logic [7:0] t_b;
    logic tx_v;
    logic [7:0] tx_b;
  } dgo_regs_s;

  dgo_regs_s s;
  dgo_regs_s next_s;

  // Parameter bytes after the opcode; bus command is sized on the fly
  function automatic logic [3:0] param_cnt(input logic [7:0] op);
    case (op)
      dgo_pkg::OP_DEFINE: param_cnt = 4'h9;
      dgo_pkg::OP_BANK_SAVE: param_cnt = 4'hA;
      dgo_pkg::OP_BANK_LOAD: param_cnt = 4'h1;
      dgo_pkg::OP_BOOT_SAVE: param_cnt = 4'h9;
      dgo_pkg::OP_MED_PLACE: param_cnt = 4'h3;
      dgo_pkg::OP_LRG_PLACE: param_cnt = 4'h2;
      dgo_pkg::OP_HBAR_DRAW: param_cnt = 4'h4;
      dgo_pkg::OP_VBAR_DRAW: param_cnt = 4'h2;
      dgo_pkg::OP_OUT_OFF: param_cnt = 4'h1;
      dgo_pkg::OP_OUT_ON: param_cnt = 4'h1;
      dgo_pkg::OP_OUT_BOOT: param_cnt = 4'h2;
      dgo_pkg::OP_SWBUS: param_cnt = 4'h1;
      default: param_cnt = 4'h0;
    endcase
  endfunction

  // Residue over address plus its CRC byte is zero when intact
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++)
    begin
      if (c[0] ^ d[i])
        c = (c >> 1) ^ dgo_pkg::CRC_POLY;
      else
        c = c >> 1;
    end
    crc8 = c;
  endfunction

  function automatic logic [7:0] pkt_byte(input dgo_regs_s r);
    case (r.pk)
      4'h0: pkt_byte = dgo_pkg::PKT_PRE_HI;
      4'h1: pkt_byte = dgo_pkg::PKT_PRE_LO;
      4'h2: pkt_byte = r.last ? dgo_pkg::PKT_FINAL
                              : dgo_pkg::PKT_MORE;
      4'h3: pkt_byte = dgo_pkg::PKT_TYPE;
      4'h4: pkt_byte = {6'h00, r.err};
      4'hD: pkt_byte = crc8(r.addr);
      default: pkt_byte = r.addr[8*(r.pk-4'h5) +: 8];
    endcase
  endfunction

  logic take;
  logic go;
  logic [7:0] op;
  logic [2:0] gi;

  assign take = rx_valid_i && s.rx_ready;

  always_comb
  begin
    next_s = s;
    go = 1'b0;
    op = s.op;
    gi = 3'h0;
    next_s.text_v = 1'b0;
    next_s.show = 1'b0;
    next_s.draw_v = 1'b0;
    next_s.st_wr = 1'b0;
    next_s.srch = 1'b0;
    next_s.t_start = 1'b0;
    next_s.t_v = 1'b0;
    next_s.tx_v = 1'b0;
    if (s.ovl_v[glyph_idx_i])
      next_s.pix = s.ovl[glyph_idx_i][glyph_row_i];
    else
      next_s.pix = s.store[s.abank][glyph_idx_i][glyph_row_i];
    // Saved state reaches the pins on the second cycle after reset
    if (s.boot)
    begin
      next_s.gout = s.boot_out;
      next_s.boot = 1'b0;
    end
    case (s.st)
      dgo_pkg::ST_IDLE:
      begin
        if (take && rx_byte_i == dgo_pkg::CMD_PREFIX)
          next_s.st = dgo_pkg::ST_OPC;
        else if (take)
        begin
          next_s.text_v = 1'b1;
          next_s.text_b = rx_byte_i;
          next_s.show = rx_byte_i < 8'h08;
        end
      end
      dgo_pkg::ST_OPC:
      begin
        if (take)
        begin
          op = rx_byte_i;
          next_s.op = rx_byte_i;
          next_s.idx = 4'h0;
          if (param_cnt(rx_byte_i) == 4'h0)
            go = 1'b1;
          else
            next_s.st = dgo_pkg::ST_PARM;
        end
      end
      dgo_pkg::ST_PARM:
      begin
        if (take)
        begin
          next_s.p[s.idx] = rx_byte_i;
          next_s.idx = s.idx + 4'h1;
          if (s.op != dgo_pkg::OP_SWBUS)
            go = (s.idx + 4'h1) == param_cnt(s.op);
          else if (s.idx == 4'h0)
          begin
            if (rx_byte_i == dgo_pkg::SUB_SEARCH)
            begin
              next_s.srch = 1'b1;
              next_s.st = dgo_pkg::ST_SRCH;
            end
            else if (rx_byte_i != dgo_pkg::SUB_TXN)
            begin
              next_s.addr = 64'h0000_0000_0000_0000;
              next_s.err = dgo_pkg::ERR_UNKNOWN;
              next_s.last = 1'b1;
              next_s.pk = 4'h0;
              next_s.st = dgo_pkg::ST_PKT;
            end
          end
          else if (s.idx == 4'h3)
          begin
            // Flag bits go to the engine untouched
            next_s.t_start = 1'b1;
            next_s.t_flags = s.p[1];
            next_s.t_send = s.p[2];
            next_s.t_recv = rx_byte_i;
            next_s.rem = s.p[2];
            if (s.p[2] == 8'h00)
              next_s.st = dgo_pkg::ST_IDLE;
            else
              next_s.st = dgo_pkg::ST_TXD;
          end
        end
      end
      dgo_pkg::ST_SRCH:
      begin
        if (sw_found_valid_i)
        begin
          next_s.addr = sw_found_addr_i;
          next_s.err = sw_found_err_i;
          next_s.last = sw_found_last_i || sw_found_err_i != 2'h0;
          next_s.pk = 4'h0;
          next_s.st = dgo_pkg::ST_PKT;
        end
      end
      dgo_pkg::ST_PKT:
      begin
        next_s.tx_v = 1'b1;
        next_s.tx_b = pkt_byte(s);
        next_s.pk = s.pk + 4'h1;
        if (s.pk == dgo_pkg::PKT_LAST_IDX)
          next_s.st = s.last ? dgo_pkg::ST_IDLE : dgo_pkg::ST_SRCH;
      end
      dgo_pkg::ST_TXD:
      begin
        if (take)
        begin
          next_s.t_v = 1'b1;
          next_s.t_b = rx_byte_i;
          next_s.rem = s.rem - 8'h01;
          if (s.rem == 8'h01)
            next_s.st = dgo_pkg::ST_IDLE;
        end
      end
      default: next_s.st = dgo_pkg::ST_IDLE;
    endcase
    if (go)
    begin
      next_s.st = dgo_pkg::ST_IDLE;
      case (op)
        dgo_pkg::OP_DEFINE:
        begin
          gi = next_s.p[0][2:0];
          for (int r = 0; r < dgo_pkg::ROWS; r++)
            next_s.ovl[gi][r] = next_s.p[r+1][4:0];
          next_s.ovl_v[gi] = 1'b1;
        end
        dgo_pkg::OP_BANK_SAVE:
        begin
          gi = next_s.p[1][2:0];
          if (next_s.p[0] < 8'(dgo_pkg::BANKS))
          begin
            next_s.st_wr = 1'b1;
            for (int r = 0; r < dgo_pkg::ROWS; r++)
              next_s.store[next_s.p[0][2:0]][gi][r] =
                next_s.p[r+2][4:0];
          end
        end
        dgo_pkg::OP_BANK_LOAD:
        begin
          if (next_s.p[0] < 8'(dgo_pkg::BANKS))
          begin
            next_s.abank = next_s.p[0][2:0];
            next_s.ovl_v = 8'h00;
          end
        end
        dgo_pkg::OP_BOOT_SAVE:
        begin
          gi = next_s.p[0][2:0];
          next_s.st_wr = 1'b1;
          for (int r = 0; r < dgo_pkg::ROWS; r++)
            next_s.store[dgo_pkg::BANK_BOOT][gi][r] =
              next_s.p[r+1][4:0];
        end
        dgo_pkg::OP_MED_INIT,
        dgo_pkg::OP_LRG_INIT,
        dgo_pkg::OP_HBAR_INIT,
        dgo_pkg::OP_VNAR_INIT,
        dgo_pkg::OP_VWIDE_INIT:
        begin
          next_s.ovl_v = 8'h00;
          case (op)
            dgo_pkg::OP_MED_INIT: next_s.abank = dgo_pkg::BANK_MED;
            dgo_pkg::OP_LRG_INIT: next_s.abank = dgo_pkg::BANK_LRG;
            dgo_pkg::OP_HBAR_INIT: next_s.abank = dgo_pkg::BANK_HBAR;
            default: next_s.abank = dgo_pkg::BANK_VBAR;
          endcase
          next_s.vwide = op == dgo_pkg::OP_VWIDE_INIT;
        end
        dgo_pkg::OP_MED_PLACE,
        dgo_pkg::OP_LRG_PLACE,
        dgo_pkg::OP_HBAR_DRAW,
        dgo_pkg::OP_VBAR_DRAW:
        begin
          // Renderer owns the glyph layout; host loaded the bank
          next_s.draw_v = 1'b1;
          next_s.draw = {next_s.p[3], next_s.p[2],
                         next_s.p[1], next_s.p[0]};
          case (op)
            dgo_pkg::OP_MED_PLACE: next_s.draw_k = dgo_pkg::DRAW_MED;
            dgo_pkg::OP_LRG_PLACE: next_s.draw_k = dgo_pkg::DRAW_LRG;
            dgo_pkg::OP_HBAR_DRAW: next_s.draw_k = dgo_pkg::DRAW_HBAR;
            default:
            begin
              next_s.draw_k = dgo_pkg::DRAW_VBAR;
              next_s.draw[2] = {7'h00, s.vwide};
            end
          endcase
        end
        dgo_pkg::OP_OUT_OFF,
        dgo_pkg::OP_OUT_ON:
        begin
          if (next_s.p[0] >= 8'h01 && next_s.p[0] <= 8'(dgo_pkg::OUTS))
            next_s.gout[next_s.p[0][2:0] - 3'h1] =
              op == dgo_pkg::OP_OUT_ON;
        end
        dgo_pkg::OP_OUT_BOOT:
        begin
          if (next_s.p[0] >= 8'h01 && next_s.p[0] <= 8'(dgo_pkg::OUTS))
          begin
            next_s.st_wr = 1'b1;
            next_s.boot_out[next_s.p[0][2:0] - 3'h1] = next_s.p[1][0];
          end
        end
        default: next_s.st = dgo_pkg::ST_IDLE;
      endcase
    end
    next_s.rx_ready = next_s.st == dgo_pkg::ST_IDLE ||
                      next_s.st == dgo_pkg::ST_OPC ||
                      next_s.st == dgo_pkg::ST_PARM ||
                      next_s.st == dgo_pkg::ST_TXD;
  end

  // Stored glyphs and start-up outputs survive reset like storage
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.st <= dgo_pkg::ST_IDLE;
      s.store <= s.store;
      s.boot_out <= s.boot_out;
      s.gout <= dgo_pkg::OUT_RST;
      s.boot <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign rx_ready_o = s.rx_ready;
  assign text_valid_o = s.text_v;
  assign text_byte_o = s.text_b;
  assign glyph_show_o = s.show;
  assign glyph_pix_o = s.pix;
  assign active_bank_o = s.abank;
  assign draw_valid_o = s.draw_v;
  assign draw_kind_o = s.draw_k;
  assign draw_a_o = s.draw[0];
  assign draw_b_o = s.draw[1];
  assign draw_c_o = s.draw[2];
  assign draw_d_o = s.draw[3];
  assign store_write_o = s.st_wr;
  assign general_output_line_o = s.gout;
  assign sw_search_req_o = s.srch;
  assign sw_txn_start_o = s.t_start;
  assign sw_txn_flags_o = s.t_flags;
  assign sw_txn_send_o = s.t_send;
  assign sw_txn_recv_o = s.t_recv;
  assign sw_txn_valid_o = s.t_v;
  assign sw_txn_byte_o = s.t_b;
  assign tx_valid_o = s.tx_v;
  assign tx_byte_o = s.tx_b;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_TEXT_PASS: assert property (
    take && s.st == dgo_pkg::ST_IDLE && rx_byte_i != 8'hFE
    |=> text_valid_o && text_byte_o == $past(rx_byte_i))
    else $error("text byte not passed on");
  AST_PREFIX_HELD: assert property (
    take && s.st == dgo_pkg::ST_IDLE && rx_byte_i == 8'hFE
    |=> !text_valid_o && s.st == dgo_pkg::ST_OPC)
    else $error("prefix byte leaked as text");
  AST_GLYPH_SHOW: assert property (
    text_valid_o |-> glyph_show_o == (text_byte_o < 8'h08))
    else $error("glyph show pulse wrong");
  AST_PKT_LEN: assert property (
    $rose(tx_valid_o) |-> tx_valid_o [*8] ##1 tx_valid_o [*6]
    ##1 !tx_valid_o)
    else $error("packet not fourteen bytes");
  AST_PKT_HEAD: assert property (
    $rose(tx_valid_o) |-> tx_byte_o == 8'h23 ##1 tx_byte_o == 8'h2A
    ##1 (tx_byte_o == 8'h8A || tx_byte_o == 8'h0A)
    ##1 tx_byte_o == 8'h31)
    else $error("packet header wrong");
  AST_UNKNOWN_ERR: assert property (
    take && s.st == dgo_pkg::ST_PARM && s.op == 8'hC8 && s.idx == 4'h0
    && rx_byte_i > 8'h02
    |=> ##1 tx_valid_o ##2 tx_byte_o == 8'h0A ##2 tx_byte_o == 8'h01)
    else $error("unknown bus command not reported");
  AST_SEARCH_REQ: assert property (
    take && s.st == dgo_pkg::ST_PARM && s.op == 8'hC8 && s.idx == 4'h0
    && rx_byte_i == 8'h02
    |=> sw_search_req_o && !rx_ready_o)
    else $error("search not requested");
  AST_TXN_START: assert property (
    take && s.st == dgo_pkg::ST_PARM && s.op == 8'hC8 && s.idx == 4'h3
    |=> sw_txn_start_o && sw_txn_recv_o == $past(rx_byte_i)
    && sw_txn_flags_o == $past(s.p[1]))
    else $error("transaction start wrong");
  AST_OUT_ON: assert property (
    take && s.st == dgo_pkg::ST_PARM && s.op == 8'h57
    && rx_byte_i == 8'h03
    |=> general_output_line_o[2])
    else $error("output not driven high");
  AST_LOAD_DROPS: assert property (
    take && s.st == dgo_pkg::ST_OPC && rx_byte_i == 8'h6D
    |=> s.ovl_v == 8'h00 && active_bank_o == 3'h3)
    else $error("unsaved glyphs kept after load");

endmodule

// ---- verilog/dgo_pkg.sv ----
/*
  Constants for the glyph, output and single-wire command decoder:
  command bytes, bank codes, packet layout and reset values.
  Assumes one synchronous clock domain; nothing here holds state.
*/
package dgo_pkg;

  // Command framing
  localparam logic [7:0] CMD_PREFIX = 8'hFE;
  localparam logic [7:0] OP_DEFINE = 8'h4E;
  localparam logic [7:0] OP_BANK_SAVE = 8'hC1;
  localparam logic [7:0] OP_BANK_LOAD = 8'hC0;
  localparam logic [7:0] OP_BOOT_SAVE = 8'hC2;
  localparam logic [7:0] OP_MED_INIT = 8'h6D;
  localparam logic [7:0] OP_MED_PLACE = 8'h6F;
  localparam logic [7:0] OP_LRG_INIT = 8'h6E;
  localparam logic [7:0] OP_LRG_PLACE = 8'h23;
  localparam logic [7:0] OP_HBAR_INIT = 8'h68;
  localparam logic [7:0] OP_HBAR_DRAW = 8'h7C;
  localparam logic [7:0] OP_VNAR_INIT = 8'h73;
  localparam logic [7:0] OP_VWIDE_INIT = 8'h76;
  localparam logic [7:0] OP_VBAR_DRAW = 8'h3D;
  localparam logic [7:0] OP_OUT_OFF = 8'h56;
  localparam logic [7:0] OP_OUT_ON = 8'h57;
  localparam logic [7:0] OP_OUT_BOOT = 8'hC3;
  localparam logic [7:0] OP_SWBUS = 8'hC8;
  localparam logic [7:0] SUB_TXN = 8'h01;
  localparam logic [7:0] SUB_SEARCH = 8'h02;

  // Glyph geometry and banks
  localparam int GLYPHS = 8;
  localparam int ROWS = 8;
  localparam int PIX = 5;
  localparam int BANKS = 5;
  localparam logic [2:0] BANK_BOOT = 3'h0;
  localparam logic [2:0] BANK_HBAR = 3'h1;
  localparam logic [2:0] BANK_VBAR = 3'h2;
  localparam logic [2:0] BANK_MED = 3'h3;
  localparam logic [2:0] BANK_LRG = 3'h4;

  // Draw request kinds
  localparam logic [2:0] DRAW_MED = 3'h1;
  localparam logic [2:0] DRAW_LRG = 3'h2;
  localparam logic [2:0] DRAW_HBAR = 3'h3;
  localparam logic [2:0] DRAW_VBAR = 3'h4;

  // General outputs
  localparam int OUTS = 6;
  localparam logic [5:0] OUT_RST = 6'h00;

  // Identification packet
  localparam logic [3:0] PKT_LAST_IDX = 4'hD;
  localparam logic [7:0] PKT_PRE_HI = 8'h23;
  localparam logic [7:0] PKT_PRE_LO = 8'h2A;
  localparam logic [7:0] PKT_MORE = 8'h8A;
  localparam logic [7:0] PKT_FINAL = 8'h0A;
  localparam logic [7:0] PKT_TYPE = 8'h31;
  localparam logic [1:0] ERR_OK = 2'h0;
  localparam logic [1:0] ERR_UNKNOWN = 2'h1;
  localparam logic [1:0] ERR_NONE = 2'h2;
  localparam logic [1:0] ERR_FATAL = 2'h3;
  localparam logic [7:0] CRC_POLY = 8'h8C;

  // Transaction flag positions
  localparam int FLG_RESET = 0;
  localparam int FLG_RDCRC = 1;
  localparam int FLG_ADDCRC = 3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_PARM = 6'h04,
    ST_SRCH = 6'h08,
    ST_PKT = 6'h10,
    ST_TXD = 6'h20
  } dgo_state_e;

endpackage

// ---- verif/dgo_host.sv ----
/*
  Host side of the byte link: sends queued command and text bytes.
  Assumes the decoder takes a byte on a rising edge with ready high.
*/
module dgo_host
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Byte link
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] q[$];

  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial
  begin
    valid_o = 1'b0;
    byte_o = 8'h00;
  end

  // Bytes leave strictly in queue order, held until taken
  always @(posedge sys_clk_i)
  begin
    if (valid_o && ready_i)
      void'(q.pop_front());
    if (rst_i || q.size() == 0)
    begin
      valid_o <= 1'b0;
      // Idle line toggles so a stale byte never looks valid
      byte_o <= ~byte_o;
    end
    else
    begin
      valid_o <= 1'b1;
      byte_o <= q[0];
    end
  end
endmodule

// ---- verif/dgo_cmd_tb.sv ----
/*
  Self-checking bench for the glyph, output and single-wire decoder.
  Assumes the host model feeds bytes; the bench plays the bus engine.
*/
module dgo_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [63:0] b;
    logic [3:0] n;
    logic [34:0] e;
    logic [5:0] sh;
    logic [2:0] bank;
  } dgo_row_s;

  localparam dgo_row_s ROWS [6] = '{
    '{64'hFE6D_FE6F_0302_0700, 4'h7,
      {dgo_pkg::DRAW_MED, 32'h0302_0700}, 6'h08, dgo_pkg::BANK_MED},
    '{64'hFE6E_FE23_1409_0000, 4'h6,
      {dgo_pkg::DRAW_LRG, 32'h1409_0000}, 6'h10, dgo_pkg::BANK_LRG},
    '{64'hFE68_FE7C_0104_0164, 4'h8,
      {dgo_pkg::DRAW_HBAR, 32'h0104_0164}, 6'h00, dgo_pkg::BANK_HBAR},
    '{64'hFE73_FE3D_1420_0000, 4'h6,
      {dgo_pkg::DRAW_VBAR, 32'h1420_0000}, 6'h08, dgo_pkg::BANK_VBAR},
    '{64'hFE76_FE3D_0100_0000, 4'h6,
      {dgo_pkg::DRAW_VBAR, 32'h0100_0100}, 6'h08, dgo_pkg::BANK_VBAR},
    '{64'hFE3D_FE05_0000_0000, 4'h4,
      {dgo_pkg::DRAW_VBAR, 32'hFE05_0100}, 6'h08, dgo_pkg::BANK_VBAR}
  };
  localparam logic [63:0] GA = 64'h0102_0408_1011_0A04;
  localparam logic [63:0] GB = 64'hFF1F_E011_2A15_0000;

  logic sys_clk = 1'b0;
  logic rst, rx_valid, rx_ready, text_valid, glyph_show, draw_valid;
  logic store_write, srch_req, f_valid, f_last, txn_start, txn_valid;
  logic tx_valid;
  logic [1:0] f_err;
  logic [2:0] glyph_idx, glyph_row, active_bank, draw_kind;
  logic [4:0] glyph_pix;
  logic [5:0] gen_out;
  logic [7:0] rx_byte, text_byte, draw_a, draw_b, draw_c, draw_d;
  logic [7:0] txn_flags, txn_send, txn_recv, txn_byte, tx_byte;
  logic [63:0] f_addr, va;
  logic [34:0] dq[$];
  logic [8:0] tq[$];
  logic [7:0] txq[$], sq[$];
  int fail_count = 0;
  int n_tests = 0;
  int n_srch = 0;
  int n_start = 0;
  int n_store = 0;

  dgo_cmd dgo_cmd_i
  (
    .sys_clk_i(sys_clk), .rst_i(rst),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready),
    .text_valid_o(text_valid), .text_byte_o(text_byte),
    .glyph_show_o(glyph_show), .glyph_idx_i(glyph_idx),
    .glyph_row_i(glyph_row), .glyph_pix_o(glyph_pix),
    .active_bank_o(active_bank), .draw_valid_o(draw_valid),
    .draw_kind_o(draw_kind), .draw_a_o(draw_a), .draw_b_o(draw_b),
    .draw_c_o(draw_c), .draw_d_o(draw_d), .store_write_o(store_write),
    .general_output_line_o(gen_out), .sw_search_req_o(srch_req),
    .sw_found_valid_i(f_valid), .sw_found_addr_i(f_addr),
    .sw_found_last_i(f_last), .sw_found_err_i(f_err),
    .sw_txn_start_o(txn_start), .sw_txn_flags_o(txn_flags),
    .sw_txn_send_o(txn_send), .sw_txn_recv_o(txn_recv),
    .sw_txn_valid_o(txn_valid), .sw_txn_byte_o(txn_byte),
    .tx_valid_o(tx_valid), .tx_byte_o(tx_byte)
  );

  dgo_host dgo_host_i
  (
    .sys_clk_i(sys_clk), .rst_i(rst), .ready_i(rx_ready),
    .valid_o(rx_valid), .byte_o(rx_byte)
  );

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (draw_valid)
      dq.push_back({draw_kind, draw_a, draw_b, draw_c, draw_d});
    if (text_valid)
      tq.push_back({glyph_show, text_byte});
    if (tx_valid)
      txq.push_back(tx_byte);
    if (txn_valid)
      sq.push_back(txn_byte);
    if (srch_req)
      n_srch++;
    if (txn_start)
      n_start++;
    if (store_write)
      n_store++;
  end

  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [63:0] a,
                                      input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++)
      c = (c >> 1) ^ ((c[0] ^ a[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction

  task automatic tx(input logic [63:0] b, input int n);
    int k;
    k = 0;
    for (int i = 0; i < n; i++)
      dgo_host_i.put(b[63 - 8 * i -: 8]);
    while ((dgo_host_i.q.size() != 0 || rx_valid) && k < 300)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    // A stalled link counts as a mismatch, not a silent skip
    if (k >= 300)
    begin
      fail_count++;
      $display("[FAIL] %0t byte not taken", $time);
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic gl(input logic [2:0] idx, input logic [63:0] rv);
    for (int r = 0; r < 8; r++)
    begin
      @(posedge sys_clk);
      glyph_idx <= idx;
      glyph_row <= r[2:0];
      @(posedge sys_clk);
      #1;
      chk(glyph_pix, rv[56 - 8 * r +: 5]);
    end
  endtask

  task automatic pkt(input logic [63:0] a, input logic l,
                     input logic [1:0] e);
    logic [111:0] x;
    logic [63:0] r;
    int k;
    // Address byte 0 leaves first
    for (int i = 0; i < 8; i++)
      r[63 - 8 * i -: 8] = a[8 * i +: 8];
    x = {16'h232A, l ? 8'h0A : 8'h8A, 8'h31, 6'h00, e, r, crc8(a, 64)};
    k = 0;
    while (txq.size() < 14 && k < 100)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (txq.size() < 14)
    begin
      fail_count++;
      $display("[FAIL] %0t answer packet short", $time);
    end
    for (int i = 0; i < 14; i++)
      chk(txq[i], x[111 - 8 * i -: 8]);
    txq.delete();
  endtask

  task automatic found(input logic [63:0] a, input logic l,
                       input logic [1:0] e);
    @(posedge sys_clk);
    f_valid <= 1'b1;
    f_addr <= a;
    f_last <= l;
    f_err <= e;
    @(posedge sys_clk);
    f_valid <= 1'b0;
    pkt(a, l | (e != 2'h0), e);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    glyph_idx = 3'h0;
    glyph_row = 3'h0;
    f_valid = 1'b0;
    f_addr = 64'h0;
    f_last = 1'b0;
    f_err = 2'h0;
    va = {crc8(64'h0011_2233_4455_6628, 56), 56'h11_2233_4455_6628};
    repeat (3) @(posedge sys_clk);
    #1;
    chk({rx_ready, draw_valid, active_bank, gen_out}, 11'h000);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      dq.delete();
      tx(ROWS[i].b, ROWS[i].n);
      chk(dq.size(), 1);
      chk(dq[0] >> ROWS[i].sh, ROWS[i].e >> ROWS[i].sh);
      chk(active_bank, ROWS[i].bank);
    end
    // Unknown opcode consumes no parameters
    tx(64'h4102_FE99_4100_0000, 5);
    chk(tq.size(), 3);
    chk({tq[0], tq[1], tq[2]}, {9'h041, 9'h102, 9'h041});
    for (int n = 1; n <= 6; n++)
      tx({16'hFE57, n[7:0], 40'h0}, 3);
    tx(64'hFE56_0300_0000_0000, 3);
    tx(64'hFE57_0700_0000_0000, 3);
    chk(gen_out, 6'h3B);
    for (int n = 1; n <= 6; n++)
      tx({16'hFEC3, n[7:0], 7'h00, n[0], 32'h0}, 4);
    chk({n_store[7:0], 2'h0, gen_out}, 16'h063B);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({rx_ready, gen_out}, 7'h55);
    n_store = 0;
    tx(64'hFEC2_0200_0000_0000, 3);
    tx(GA, 8);
    tx(64'hFEC0_0000_0000_0000, 3);
    tx(64'hFE4E_0200_0000_0000, 3);
    tx(GB, 8);
    gl(3'h2, GB);
    tx(64'hFEC0_0000_0000_0000, 3);
    gl(3'h2, GA);
    tx(64'hFEC1_0305_0000_0000, 4);
    tx(GB, 8);
    tx(64'hFEC0_0300_0000_0000, 3);
    chk(active_bank, dgo_pkg::BANK_MED);
    gl(3'h5, GB);
    chk(n_store, 2);
    // Flag bits 2 and 4 kept clear by the host
    tx(64'hFEC8_010B_0200_AAFE, 8);
    tx(64'h4100_0000_0000_0000, 1);
    chk(n_start, 1);
    chk({txn_flags, txn_send, txn_recv}, 24'h0B_0200);
    chk({sq.size(), sq[0], sq[1]}, 48'h2_AAFE);
    chk(tq[3], 9'h041);
    tx(64'hFEC8_0200_0000_0000, 3);
    chk({n_srch[7:0], rx_ready}, 9'h002);
    found(va, 1'b0, 2'h0);
    found(64'h0123_4567_89AB_CDEF, 1'b1, 2'h0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(rx_ready, 1'b1);
    for (int e = 2; e <= 3; e++)
    begin
      tx(64'hFEC8_0200_0000_0000, 3);
      found(64'h0, 1'b0, e[1:0]);
    end
    tx(64'hFEC8_0500_0000_0000, 3);
    pkt(64'h0, 1'b1, 2'h1);
    end_sim();
  end
endmodule
